// file: aeg_ctrl.sv
// Purpose: Extended analog input routing and reference ladder gate
// Assumes: Classic Wishbone slave; sample value supplied by analog core
// Notes:   One ack answers each read or write; unmapped reads return zero
`timescale 1ns/1ns
`default_nettype none
module aeg_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [9:0] sample_i,
   input wire logic hw_trig_i,
   output logic ladder_connect_o,
   output logic ext_analog_pin_a_in_o,
   output logic ext_analog_pin_a_out_o,
   output logic ext_analog_pin_b_in_o,
   output logic [2:0] mux_chan_o,
   output logic busy_o,
   output logic done_o
);
   // ----------------------------------------------------------------
   // State and registers
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      AEG_IDLE = 1'b0,
      AEG_CONV = 1'b1
   } aeg_state_t;

   aeg_state_t state_reg, state_next;
   logic [8:0] cnt_reg, cnt_next;
   logic start_reg, start_next;
   logic trig_reg, trig_next;
   logic [2:0] chan_reg, chan_next;
   logic [1:0] mode_reg, mode_next;
   logic [1:0] sel_reg, sel_next;
   logic ref_reg, ref_next;
   logic dma_mode_flag_reg, dma_mode_flag_next;
   logic [9:0] res_reg [aeg_pkg::NCH];
   logic [9:0] res_next [aeg_pkg::NCH];
   logic [2:0] dest_reg, dest_next;
   logic ack_reg, ack_next;
   logic [31:0] dat_reg, dat_next;
   logic done_reg, done_next;
   logic a_in_reg, a_out_reg, b_in_reg;
   logic [2:0] mux_reg;

   aeg_route_if rt();

   aeg_route_dec u_dec (
      .mode_i(mode_reg),
      .sel_i(sel_reg),
      .chan_i(chan_reg),
      .dma_i(dma_mode_flag_reg),
      .rt(rt)
   );

   logic req;
   logic wr;
   logic [31:0] wmask;
   logic finish;
   assign req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wr = req && wb_we_i;
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign finish = (state_reg == AEG_CONV) && (cnt_reg == 9'd0);

   // ----------------------------------------------------------------
   // Register bus and control next values
   // ----------------------------------------------------------------
   // Busy bit is read-only; start bit self-clears when a one-shot ends
   always_comb begin
      logic [31:0] c0;
      logic [31:0] c1;
      logic [31:0] nv;
      c0 = 32'h0000_0000;
      c1 = 32'h0000_0000;
      nv = 32'h0000_0000;
      c0[aeg_pkg::C0_START] = start_reg;
      c0[aeg_pkg::C0_TRIG] = trig_reg;
      c0[aeg_pkg::C0_BUSY] = (state_reg == AEG_CONV);
      c0[aeg_pkg::C0_CH_HI:aeg_pkg::C0_CH_LO] = chan_reg;
      c0[aeg_pkg::C0_MODE_HI:aeg_pkg::C0_MODE_LO] = mode_reg;
      c1[aeg_pkg::C1_SEL_HI:aeg_pkg::C1_SEL_LO] = sel_reg;
      c1[aeg_pkg::C1_REF] = ref_reg;
      start_next = start_reg;
      trig_next = trig_reg;
      chan_next = chan_reg;
      mode_next = mode_reg;
      sel_next = sel_reg;
      ref_next = ref_reg;
      dma_mode_flag_next = dma_mode_flag_reg;
      ack_next = req;
      dat_next = 32'h0000_0000;
      if (req && !wb_we_i) begin
         if (wb_adr_i == aeg_pkg::ADR_CTRL0) begin
            dat_next = c0;
         end else if (wb_adr_i == aeg_pkg::ADR_CTRL1) begin
            dat_next = c1;
         end else if (wb_adr_i == aeg_pkg::ADR_CTRL3) begin
            dat_next = {31'h0, dma_mode_flag_reg};
         end else if (wb_adr_i >= aeg_pkg::ADR_RES_BASE &&
                      wb_adr_i <= aeg_pkg::ADR_RES_LAST && wb_adr_i[1:0] == 2'b00) begin
            dat_next = {22'h0, res_reg[wb_adr_i[4:2]]};
         end
      end
      if (finish && mode_reg == aeg_pkg::AEG_MODE_ONESHOT) begin
         start_next = 1'b0;
      end
      if (wr && wb_adr_i == aeg_pkg::ADR_CTRL0) begin
         nv = (c0 & ~wmask) | (wb_dat_i & wmask);
         start_next = nv[aeg_pkg::C0_START];
         trig_next = nv[aeg_pkg::C0_TRIG];
         chan_next = nv[aeg_pkg::C0_CH_HI:aeg_pkg::C0_CH_LO];
         mode_next = nv[aeg_pkg::C0_MODE_HI:aeg_pkg::C0_MODE_LO];
      end
      if (wr && wb_adr_i == aeg_pkg::ADR_CTRL1) begin
         nv = (c1 & ~wmask) | (wb_dat_i & wmask);
         sel_next = nv[aeg_pkg::C1_SEL_HI:aeg_pkg::C1_SEL_LO];
         ref_next = nv[aeg_pkg::C1_REF];
      end
      if (wr && wb_adr_i == aeg_pkg::ADR_CTRL3 && wb_sel_i[0]) begin
         dma_mode_flag_next = wb_dat_i[aeg_pkg::C3_DMA];
      end
   end

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   // Start only with the ladder already connected; an unpowered ladder gives junk
   always_comb begin
      logic go;
      go = start_reg && ref_reg && (!trig_reg || hw_trig_i);
      state_next = state_reg;
      cnt_next = cnt_reg;
      dest_next = dest_reg;
      done_next = 1'b0;
      for (int i = 0; i < aeg_pkg::NCH; i++) begin
         res_next[i] = res_reg[i];
      end
      unique case (state_reg)
         AEG_IDLE: begin
            if (go) begin
               state_next = AEG_CONV;
               cnt_next = 9'(aeg_pkg::CONV_CYC - 1);
               dest_next = rt.dest;
            end
         end
         AEG_CONV: begin
            if (!start_reg) begin
               state_next = AEG_IDLE;
            end else if (cnt_reg != 9'd0) begin
               cnt_next = cnt_reg - 9'd1;
            end else begin
               res_next[dest_reg] = sample_i;
               done_next = 1'b1;
               state_next = AEG_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= AEG_IDLE;
         cnt_reg <= 9'd0;
         start_reg <= 1'b0;
         trig_reg <= 1'b0;
         chan_reg <= 3'd0;
         mode_reg <= 2'b00;
         sel_reg <= 2'b00;
         ref_reg <= 1'b0;
         dma_mode_flag_reg <= 1'b0;
         dest_reg <= 3'd0;
         ack_reg <= 1'b0;
         dat_reg <= aeg_pkg::CTRL_RST;
         done_reg <= 1'b0;
         a_in_reg <= 1'b0;
         a_out_reg <= 1'b0;
         b_in_reg <= 1'b0;
         mux_reg <= 3'd0;
         for (int i = 0; i < aeg_pkg::NCH; i++) begin
            res_reg[i] <= aeg_pkg::RES_RST;
         end
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         start_reg <= start_next;
         trig_reg <= trig_next;
         chan_reg <= chan_next;
         mode_reg <= mode_next;
         sel_reg <= sel_next;
         ref_reg <= ref_next;
         dma_mode_flag_reg <= dma_mode_flag_next;
         dest_reg <= dest_next;
         ack_reg <= ack_next;
         dat_reg <= dat_next;
         done_reg <= done_next;
         a_in_reg <= rt.ext_a_in;
         a_out_reg <= rt.ext_a_out;
         b_in_reg <= rt.ext_b_in;
         mux_reg <= chan_reg;
         for (int i = 0; i < aeg_pkg::NCH; i++) begin
            res_reg[i] <= res_next[i];
         end
      end
   end

   // Ladder gate only; D/A reference is outside this block
   assign ladder_connect_o = ref_reg;
   assign ext_analog_pin_a_in_o = a_in_reg;
   assign ext_analog_pin_a_out_o = a_out_reg;
   assign ext_analog_pin_b_in_o = b_in_reg;
   assign mux_chan_o = mux_reg;
   assign busy_o = (state_reg == AEG_CONV);
   assign done_o = done_reg;
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Cycles spent converting, counted apart from the sequencer's own counter
   logic [8:0] age_reg, age_next;

   always_comb begin
      age_next = age_reg;
      if (state_reg == AEG_IDLE && state_next == AEG_CONV) begin
         age_next = 9'd0;
      end else if (state_reg == AEG_CONV) begin
         age_next = age_reg + 9'd1;
      end
   end

   // Helper register only; it feeds nothing but the checks below
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         age_reg <= 9'd0;
      end else begin
         age_reg <= age_next;
      end
   end

   sequence s_start;
      state_reg == AEG_IDLE && state_next == AEG_CONV;
   endsequence

   sequence s_conv_last;
      busy_o && start_reg && age_reg == 9'(aeg_pkg::CONV_CYC - 1);
   endsequence

   a_start_needs_ref: assert property (@(posedge clk_i) disable iff (rst_i)
      s_start |-> ref_reg) else $error("conversion began without ladder");
   a_dma_first_slot: assert property (@(posedge clk_i) disable iff (rst_i)
      s_start and dma_mode_flag_reg |=> dest_reg == 3'd0) else $error("dma dest wrong");
   a_pin_a_slot: assert property (@(posedge clk_i) disable iff (rst_i)
      s_start and rt.ext_a_in |=> dest_reg == 3'd0) else $error("pin a dest wrong");
   a_pin_b_slot: assert property (@(posedge clk_i) disable iff (rst_i)
      s_start and (sel_reg == 2'b10 && mode_reg == 2'b00 && !dma_mode_flag_reg)
      |=> dest_reg == 3'd1) else $error("pin b dest wrong");
   a_loop_route: assert property (@(posedge clk_i) disable iff (rst_i)
      sel_reg == 2'b11 && mode_reg[1] == 1'b0 && $stable(sel_reg) && $stable(mode_reg)
      |=> ext_analog_pin_a_out_o && ext_analog_pin_b_in_o) else $error("loop route");
   a_sweep_no_ext: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_reg[1] |=> !ext_analog_pin_a_in_o || $past(!mode_reg[1])) else $error("sweep ext");
   a_conv_length: assert property (@(posedge clk_i) disable iff (rst_i)
      done_reg |-> age_reg == 9'(aeg_pkg::CONV_CYC)) else $error("conversion length");
   a_conv_done: assert property (@(posedge clk_i) disable iff (rst_i)
      s_conv_last |=> done_reg) else $error("conversion never finished");
   a_ladder_follows: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && wb_adr_i == aeg_pkg::ADR_CTRL1 && wb_sel_i[0]
      |=> ladder_connect_o == $past(wb_dat_i[2])) else $error("ladder gate");
endmodule // aeg_ctrl
`default_nettype wire

// file: aeg_pkg.sv
// Purpose: Constants for the extended-input and reference-gate control block
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes:   Register layout and timing counts live here only
//
// Overview of operation
// - Extended pins only in one-shot/repeat modes
// - Select 00 none, 01 pin a, 10 pin b, 11 loop
// - Pin a result goes to first register
// - Pin b to second, first when DMA mode
// - Loop mode routes main channel out pin a
// - Loop mode stores pin b in channel register
// - Reference bit connects ladder when one
// - Reference bit leaves D/A reference alone
// - DMA mode stores all results first register
// - Software trigger starts on start bit write
package aeg_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL0 = 8'h00;
   localparam logic [7:0] ADR_CTRL1 = 8'h04;
   localparam logic [7:0] ADR_CTRL3 = 8'h08;
   localparam logic [7:0] ADR_SAMPLE = 8'h0C;
   localparam logic [7:0] ADR_RES_BASE = 8'h20;
   localparam logic [7:0] ADR_RES_LAST = 8'h3C;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int C0_START = 0;
   localparam int C0_TRIG = 1;
   localparam int C0_BUSY = 2;
   localparam int C0_CH_LO = 4;
   localparam int C0_CH_HI = 6;
   localparam int C0_MODE_LO = 8;
   localparam int C0_MODE_HI = 9;
   localparam int C1_SEL_LO = 0;
   localparam int C1_SEL_HI = 1;
   localparam int C1_REF = 2;
   localparam int C3_DMA = 0;

   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [9:0] RES_RST = 10'h000;
   localparam int RES_W = 10;
   localparam int NCH = 8;

   typedef enum logic [1:0] {
      AEG_MODE_ONESHOT = 2'b00,
      AEG_MODE_REPEAT = 2'b01,
      AEG_MODE_SWEEP = 2'b10,
      AEG_MODE_SWEEP_R = 2'b11
   } aeg_mode_t;

   typedef enum logic [1:0] {
      AEG_SEL_NONE = 2'b00,
      AEG_SEL_PIN_A = 2'b01,
      AEG_SEL_PIN_B = 2'b10,
      AEG_SEL_LOOP = 2'b11
   } aeg_sel_t;

   // ----------------------------------------------------------------
   // Timing: conversion time per sample
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int CONV_NS = 330;
   localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
endpackage

// file: aeg_route_if.sv
// Purpose: Routing decision carried from decoder to control block
// Assumes: One clock domain
// Notes:   Decoder drives, top reads
`timescale 1ns/1ns
`default_nettype none
interface aeg_route_if;
   logic ext_a_in;
   logic ext_a_out;
   logic ext_b_in;
   logic use_ext;
   logic [2:0] dest;
   modport dec(output ext_a_in, output ext_a_out, output ext_b_in, output use_ext, output dest);
   modport ctl(input ext_a_in, input ext_a_out, input ext_b_in, input use_ext, input dest);
endinterface
`default_nettype wire

// file: aeg_route_dec.sv
// Purpose: Decode extended-pin select into pin roles and result slot
// Assumes: Mode, select, channel and DMA flag are registered
// Notes:   Pure combinational
`timescale 1ns/1ns
`default_nettype none
module aeg_route_dec (
   input wire logic [1:0] mode_i,
   input wire logic [1:0] sel_i,
   input wire logic [2:0] chan_i,
   input wire logic dma_i,
   aeg_route_if.dec rt
);
   // ----------------------------------------------------------------
   // Pin roles and destination
   // ----------------------------------------------------------------
   // Sweep modes ignore the select field entirely
   always_comb begin
      logic single;
      single = (mode_i == aeg_pkg::AEG_MODE_ONESHOT) ||
               (mode_i == aeg_pkg::AEG_MODE_REPEAT);
      rt.ext_a_in = 1'b0;
      rt.ext_a_out = 1'b0;
      rt.ext_b_in = 1'b0;
      rt.use_ext = 1'b0;
      rt.dest = chan_i;
      if (single) begin
         unique case (sel_i)
            aeg_pkg::AEG_SEL_NONE: begin
               rt.dest = chan_i;
            end
            aeg_pkg::AEG_SEL_PIN_A: begin
               rt.ext_a_in = 1'b1;
               rt.use_ext = 1'b1;
               rt.dest = 3'd0;
            end
            aeg_pkg::AEG_SEL_PIN_B: begin
               rt.ext_b_in = 1'b1;
               rt.use_ext = 1'b1;
               rt.dest = 3'd1;
            end
            aeg_pkg::AEG_SEL_LOOP: begin
               rt.ext_a_out = 1'b1;
               rt.ext_b_in = 1'b1;
               rt.use_ext = 1'b1;
               rt.dest = chan_i;
            end
         endcase
      end
      if (dma_i) begin
         rt.dest = 3'd0;
      end
   end
endmodule // aeg_route_dec
`default_nettype wire

// file: aeg_analog_model.sv
// Purpose: Analog side model: main inputs, extended pins, external amplifier
// Assumes: Levels settle well before the core captures a sample
// Notes:   Loop value is the main channel level seen back through the amplifier
`timescale 1ns/1ns
`default_nettype none
module aeg_analog_model #(
   parameter logic [9:0] PIN_A_V = 10'h01A5,
   parameter logic [9:0] PIN_B_V = 10'h02B3,
   parameter logic [9:0] LOOP_V = 10'h0300,
   parameter logic [9:0] MAIN_V = 10'h0040
) (
   input wire logic clk_i,
   input wire logic ladder_i,
   input wire logic pin_a_in_i,
   input wire logic pin_a_out_i,
   input wire logic pin_b_in_i,
   input wire logic [2:0] chan_i,
   output logic [9:0] sample_o
);
   logic [9:0] junk_reg = 10'h0155;

   // ------------------------------------------------------------
   // Source selection
   // ------------------------------------------------------------
   // Ladder isolated: no valid level, so a stray capture shows up
   always @(posedge clk_i) begin
      junk_reg <= ~junk_reg;
   end

   // Amplifier output only exists while pin a drives it
   always_comb begin
      if (!ladder_i) begin
         sample_o = junk_reg;
      end else if (pin_b_in_i && pin_a_out_i) begin
         sample_o = LOOP_V + 10'(chan_i);
      end else if (pin_b_in_i) begin
         sample_o = PIN_B_V;
      end else if (pin_a_in_i) begin
         sample_o = PIN_A_V;
      end else begin
         sample_o = MAIN_V + 10'(chan_i);
      end
   end
endmodule // aeg_analog_model
`default_nettype wire

// file: tb_aeg_ctrl.sv
// Purpose: Self-checking bench for extended input routing and ladder gate
// Assumes: Software trigger, plus one hardware strobe case; sample from the analog model
// Notes:   Bus ack and data sampled on the rising edge, other outputs on the falling except the reset ladder check; inputs driven on the rising
`timescale 1ns/1ns
`default_nettype none
module tb_aeg_ctrl;
   localparam logic [9:0] PA = 10'h01A5;
   localparam logic [9:0] PB = 10'h02B3;
   localparam logic [9:0] LP = 10'h0300;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic htrig = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, rd;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, ladder, pa_in, pa_out, pb_in, busy, done;
   logic [2:0] mux;
   logic [9:0] sample;
   int mismatches = 0;
   int checks = 0;

   // ------------------------------------------------------------
   // Clock, design and analog side
   // ------------------------------------------------------------
   always #5 clk_i = ~clk_i;

   aeg_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_i(sample), .hw_trig_i(htrig),
      .ladder_connect_o(ladder), .ext_analog_pin_a_in_o(pa_in),
      .ext_analog_pin_a_out_o(pa_out), .ext_analog_pin_b_in_o(pb_in),
      .mux_chan_o(mux), .busy_o(busy), .done_o(done));

   aeg_analog_model #(.PIN_A_V(PA), .PIN_B_V(PB), .LOOP_V(LP)) ana (.clk_i(clk_i),
      .ladder_i(ladder), .pin_a_in_i(pa_in), .pin_a_out_i(pa_out), .pin_b_in_i(pb_in),
      .chan_i(mux), .sample_o(sample));

   // ------------------------------------------------------------
   // Bus cycles and comparison
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Single classic cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      if (n >= 50) chk("ack", 32'h1, 32'h0);
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk_i);
   endtask

   function automatic logic [31:0] c0(input logic [1:0] m, input logic [2:0] ch,
                                      input logic st);
      return {22'h0, m, 1'b0, ch, 3'b000, st};
   endfunction

   // Let registered pin roles settle, then look between edges
   task automatic settle();
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   // DMA flag first, then ladder in its own write, select while idle, then start
   task automatic conv(input logic [1:0] sl, input logic [1:0] m, input logic [2:0] ch,
                       input logic dma, input int idx, input logic [9:0] exp);
      int n;
      n = 0;
      wb(1'b1, aeg_pkg::ADR_CTRL3, {31'h0, dma});
      wb(1'b1, aeg_pkg::ADR_CTRL1, 32'h0000_0004);
      wb(1'b1, aeg_pkg::ADR_CTRL1, {29'h0, 1'b1, sl});
      wb(1'b1, aeg_pkg::ADR_CTRL0, c0(m, ch, 1'b1));
      do begin
         @(negedge clk_i);
         n++;
      end while (done !== 1'b1 && n < 100);
      chk("done", 32'h1, {31'h0, done});
      wb(1'b1, aeg_pkg::ADR_CTRL0, c0(m, ch, 1'b0));
      settle();
      chk("idle", 32'h0, {31'h0, busy});
      wb(1'b0, aeg_pkg::ADR_RES_BASE + 8'(idx * 4), 32'h0);
      chk("result", {22'h0, exp}, rd);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      wb(1'b0, aeg_pkg::ADR_CTRL1, 32'h0);
      chk("ctrl1 reset", aeg_pkg::CTRL_RST, rd);
      wb(1'b0, aeg_pkg::ADR_CTRL0, 32'h0);
      chk("ctrl0 reset", aeg_pkg::CTRL_RST, rd);
      chk("ladder reset", 32'h0, {31'h0, ladder});
      wb(1'b1, aeg_pkg::ADR_SAMPLE, 32'hFFFF_FFFF);
      wb(1'b0, aeg_pkg::ADR_SAMPLE, 32'h0);
      chk("unmapped", 32'h0, rd);
   endtask

   task automatic t_ladder();
      wb(1'b1, aeg_pkg::ADR_CTRL1, 32'h0000_0004);
      settle();
      chk("ladder on", 32'h1, {31'h0, ladder});
      wb(1'b1, aeg_pkg::ADR_CTRL1, 32'h0000_0000);
      settle();
      chk("ladder off", 32'h0, {31'h0, ladder});
   endtask

   // Start with the ladder isolated must not convert
   task automatic t_no_ref();
      wb(1'b1, aeg_pkg::ADR_CTRL0, c0(2'b00, 3'd0, 1'b1));
      repeat (60) @(negedge clk_i);
      chk("no conv", 32'h0, {31'h0, busy});
      wb(1'b1, aeg_pkg::ADR_CTRL0, 32'h0);
   endtask

   task automatic t_loop();
      wb(1'b1, aeg_pkg::ADR_CTRL1, 32'h0000_0007);
      wb(1'b1, aeg_pkg::ADR_CTRL0, c0(2'b00, 3'd5, 1'b0));
      settle();
      chk("loop pins", 32'h6, {29'h0, pa_out, pb_in, pa_in});
      chk("loop chan", 32'h5, {29'h0, mux});
      conv(2'b11, 2'b00, 3'd5, 1'b0, 5, LP + 10'd5);
      conv(2'b11, 2'b01, 3'd7, 1'b0, 7, LP + 10'd7);
   endtask

   task automatic t_sweep();
      wb(1'b1, aeg_pkg::ADR_CTRL1, 32'h0000_0005);
      wb(1'b1, aeg_pkg::ADR_CTRL0, c0(2'b10, 3'd0, 1'b0));
      settle();
      chk("sweep pin a", 32'h0, {31'h0, pa_in});
      wb(1'b1, aeg_pkg::ADR_CTRL0, c0(2'b00, 3'd0, 1'b0));
      settle();
      chk("oneshot pin a", 32'h1, {31'h0, pa_in});
   endtask

   // Trigger bit set: a stored start waits for the hardware strobe
   task automatic t_hw_trig();
      int n;
      n = 0;
      wb(1'b1, aeg_pkg::ADR_CTRL1, 32'h0000_0004);
      wb(1'b1, aeg_pkg::ADR_CTRL0, c0(2'b00, 3'd4, 1'b1) | 32'h0000_0002);
      repeat (10) @(negedge clk_i);
      chk("trig wait", 32'h0, {31'h0, busy});
      @(posedge clk_i);
      htrig <= 1'b1;
      do begin
         @(negedge clk_i);
         n++;
      end while (done !== 1'b1 && n < 100);
      chk("trig done", 32'h1, {31'h0, done});
      @(posedge clk_i);
      htrig <= 1'b0;
      wb(1'b1, aeg_pkg::ADR_CTRL0, 32'h0);
   endtask

   // ------------------------------------------------------------
   // Verdict, watchdog and main sequence
   // ------------------------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Whole run is under a thousand cycles; this is 40000 cycles, over forty times that
   initial begin
      #400000;
      mismatches++;
      results();
   end

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_ladder();
      t_no_ref();
      conv(2'b01, 2'b00, 3'd2, 1'b0, 0, PA);
      conv(2'b01, 2'b01, 3'd2, 1'b0, 0, PA);
      conv(2'b10, 2'b00, 3'd3, 1'b0, 1, PB);
      conv(2'b10, 2'b00, 3'd3, 1'b1, 0, PB);
      conv(2'b00, 2'b00, 3'd4, 1'b0, 4, 10'h0044);
      t_loop();
      t_sweep();
      t_hw_trig();
      results();
   end
endmodule // tb_aeg_ctrl
`default_nettype wire
